// [sim/sar_comp_model.sv]
// comparator model standing for the analog side
// assumes LEVEL is the held input in offset binary
`timescale 1ns/1ps
module sar_comp_model (
   input  wire logic        CLOCK,
   input  wire logic [11:0] LEVEL,
   input  wire logic [11:0] DAC_CODE,
   output logic             COMP_GE
);
   // one stage, well inside the settle margin
   always @(posedge CLOCK) begin
      COMP_GE <= (LEVEL >= DAC_CODE);
   end
endmodule // sar_comp_model

// [sim/sar_readout_sva.sv]
// port checker for the sar serial readout
// assumes shift clock periods far longer than CLOCK
`timescale 1ns/1ps
module sar_readout_sva #(parameter RES_W = 12) (
   input wire logic             CLOCK,
   input wire logic             RSTN,
   input wire logic             CS_N,
   input wire logic             SHIFT_CLOCK,
   input wire logic             DOUT,
   input wire logic             DOUT_OE,
   input wire logic             INPUT_CONNECT,
   input wire logic [RES_W-1:0] RESULT,
   input wire logic             ANALOG_PD
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   sequence s_quiet;
      !DOUT_OE && ANALOG_PD;
   endsequence
   AST_START: assert property ($fell(CS_N) |-> ##[3:5] INPUT_CONNECT)
      else $error("no sampling after select fall");
   AST_ABORT: assert property ($rose(CS_N) |-> ##[1:5] s_quiet)
      else $error("output not released after select rise");
   AST_ON_FALL: assert property ($changed(DOUT) && DOUT_OE |-> !SHIFT_CLOCK)
      else $error("output changed with shift clock high");
   AST_NULL: assert property ($rose(DOUT_OE) |-> !DOUT)
      else $error("first bit not low");
   AST_NULL_LEN: assert property ($rose(DOUT_OE) |=> $stable(DOUT)[*8])
      else $error("low bit too short");
   AST_CONNECT: assert property (INPUT_CONNECT |-> !DOUT_OE && !ANALOG_PD)
      else $error("input connected outside sampling");
   AST_IDLE: assert property (CS_N [*6] |-> !DOUT_OE)
      else $error("output driven while deselected");
   AST_RESULT: assert property ($changed(RESULT) |-> DOUT_OE && !CS_N)
      else $error("result changed outside a read");
endmodule // sar_readout_sva
bind sar_adc_serial_readout sar_readout_sva #(.RES_W(RES_W)) u_sva (
   .CLOCK(CLOCK), .RSTN(RSTN), .CS_N(CS_N), .SHIFT_CLOCK(SHIFT_CLOCK),
   .DOUT(DOUT), .DOUT_OE(DOUT_OE), .INPUT_CONNECT(INPUT_CONNECT),
   .RESULT(RESULT), .ANALOG_PD(ANALOG_PD));

// [sim/test_sar_adc_serial_readout.sv]
// bench for the sar serial readout: full, overlong and cut-short reads
// assumes the comparator model stands for the analog side
`timescale 1ns/1ps
module test_sar_adc_serial_readout;
   localparam int H = 40; // half shift period 160 ns
   logic        CLOCK = 1'b0;
   logic        RSTN = 1'b0;
   logic        CS_N = 1'b1;
   logic        SHIFT_CLOCK = 1'b0;
   logic        COMP_GE;
   logic [11:0] level = 12'h000;
   logic [11:0] last = 12'h000;
   wire         DOUT, DOUT_OE, INPUT_CONNECT, ANALOG_PD, DIGITAL_PD;
   wire  [11:0] DAC_CODE, RESULT;
   int          n_errors = 0;
   int          n_tests = 0;
   sar_adc_serial_readout u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .CS_N(CS_N),
      .SHIFT_CLOCK(SHIFT_CLOCK), .COMP_GE(COMP_GE), .DOUT(DOUT),
      .DOUT_OE(DOUT_OE), .INPUT_CONNECT(INPUT_CONNECT), .DAC_CODE(DAC_CODE),
      .RESULT(RESULT), .ANALOG_PD(ANALOG_PD), .DIGITAL_PD(DIGITAL_PD));
   sar_comp_model u_comp (.CLOCK(CLOCK), .LEVEL(level),
      .DAC_CODE(DAC_CODE), .COMP_GE(COMP_GE));
   initial begin
      forever #2 CLOCK = ~CLOCK;
   end
   task chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task conclude;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one read of nf clocks; reads of fewer than 14 clocks keep the old result
   task conv(input logic [11:0] lvl, input int nf);
      logic [11:0] w;
      logic        b;
      logic        oe;
      logic [2:0]  st;
      w = lvl ^ 12'h800;
      level <= lvl;
      CS_N <= 1'b0; // shift clock low here
      // a bit seen at rise k was put out at fall k-1
      for (int k = 1; k <= nf; k++) begin
         repeat (H) @(posedge CLOCK);
         SHIFT_CLOCK <= 1'b1;
         b = DOUT; // taken at the rise
         oe = DOUT_OE;
         st = {INPUT_CONNECT, ANALOG_PD, DIGITAL_PD};
         if (k == 1)
            chk("sampling", 12'(st), 12'h004);
         else if (k == 3)
            chk("held", 12'(st), 12'h000);
         else if (k == 15)
            chk("analog off", 12'(st), 12'h002);
         if (k == 15)
            chk("trial word", DAC_CODE, lvl);
         repeat (H) @(posedge CLOCK);
         SHIFT_CLOCK <= 1'b0;
         if (k == 3)
            chk("null", 12'({oe, b}), 12'h002);
         else if (k >= 4 && k <= 15)
            chk("msb first", 12'({oe, b}), 12'({1'b1, w[15-k]}));
         else if (k >= 16 && k <= 26)
            chk("lsb first", 12'({oe, b}), 12'({1'b1, w[k-15]}));
         else if (k >= 27)
            chk("tristate", 12'(oe), 12'h000);
      end
      repeat (H) @(posedge CLOCK);
      CS_N <= 1'b1;
      repeat (8) @(posedge CLOCK);
      chk("oe off", 12'(DOUT_OE), 12'h000);
      chk("power down", 12'({ANALOG_PD, DIGITAL_PD}), 12'h003);
      if (nf >= 14)
         last = w;
      chk("result", RESULT, last);
   endtask
   // reset between reads with select already low must not start anything
   task reset_low_select;
      RSTN <= 1'b0;
      CS_N <= 1'b0;
      repeat (4) @(posedge CLOCK);
      chk("reset oe", 12'(DOUT_OE), 12'h000);
      chk("reset pd", 12'({ANALOG_PD, DIGITAL_PD}), 12'h003);
      chk("reset result", RESULT, 12'h000);
      RSTN <= 1'b1;
      for (int k = 1; k <= 4; k++) begin
         repeat (H) @(posedge CLOCK);
         SHIFT_CLOCK <= 1'b1;
         repeat (H) @(posedge CLOCK);
         SHIFT_CLOCK <= 1'b0;
         chk("no start", 12'({DOUT_OE, INPUT_CONNECT}), 12'h000);
      end
      CS_N <= 1'b1;
      repeat (8) @(posedge CLOCK);
      last = 12'h000;
   endtask
   initial begin
      repeat (100000) @(posedge CLOCK);
      n_errors++;
      conclude;
   end
   initial begin
      repeat (8) @(posedge CLOCK);
      RSTN <= 1'b1;
      repeat (4) @(posedge CLOCK);
      conv(12'hFFF, 28); // clocks past the end are ignored
      conv(12'h000, 26);
      conv(12'h7FF, 26);
      conv(12'h800, 26);
      conv(12'h5A3, 8); // cut short
      reset_low_select;
      conv(12'h5A3, 26);
      conclude;
   end
endmodule // test_sar_adc_serial_readout

// [src/pin_sync.v]
// two-flop synchroniser for one asynchronous pin
// assumes the pin is not related to CLOCK; output read by logic only
`timescale 1ns/1ps
module pin_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire CLOCK,
   input  wire RSTN,
   input  wire PIN,
   output wire LEVEL
);
   reg stage1_reg;
   reg stage2_reg;

   // first stage feeds only the second one
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         stage1_reg <= RST_VAL;
         stage2_reg <= RST_VAL;
      end else begin
         stage1_reg <= PIN;
         stage2_reg <= stage1_reg;
      end
   end

   assign LEVEL = stage2_reg;
endmodule // pin_sync

// [src/sar_adc_serial_readout.v]
// sequencing and serial readout of a 12-bit differential sar converter
// assumes CS_N, SHIFT_CLOCK and COMP_GE are asynchronous pins, CLOCK far
// faster than the shift clock (3.2 MHz max against 250 MHz)
// RSTN is local only; the pins carry no reset of their own
`timescale 1ns/1ps
`include "sar_readout_defs.vh"
module sar_adc_serial_readout #(
   parameter RES_W = `RES_WIDTH
) (
   input  wire             CLOCK,
   input  wire             RSTN,
   input  wire             CS_N,
   input  wire             SHIFT_CLOCK,
   input  wire             COMP_GE,
   output reg              DOUT,
   output reg              DOUT_OE,
   output reg              INPUT_CONNECT,
   output reg  [RES_W-1:0] DAC_CODE,
   output reg  [RES_W-1:0] RESULT,
   output reg              ANALOG_PD,
   output reg              DIGITAL_PD
);
   wire                   cs_n_s;
   wire                   sclk_s;
   wire                   comp_s;
   reg                    cs_n_d_reg;
   reg                    sclk_d_reg;
   reg  [1:0]             state_reg;
   reg  [`EDGE_CNT_W-1:0] edge_cnt_reg;
   reg  [3:0]             bit_idx_reg;
   wire                   start;
   wire                   abort;
   wire                   sclk_fall;
   wire                   sclk_rise;
   wire [`EDGE_CNT_W-1:0] edge_next;
   wire [RES_W-1:0]       code;
   reg  [1:0]             flush_cnt_reg;
   wire                   sync_valid;
   wire                   null_edge;
   wire                   in_msbf;
   wire                   in_lsbf;
   wire                   result_load;

   // offset-binary trial word to two's complement
   function [RES_W-1:0] to_twos;
      input [RES_W-1:0] ob;
      begin
         to_twos = {~ob[RES_W-1], ob[RES_W-2:0]};
      end
   endfunction

   // repeat phase bit position, cut to the index width on purpose
   function [3:0] repeat_idx;
      input [`EDGE_CNT_W-1:0] cnt;
      reg   [`EDGE_CNT_W-1:0] diff;
      begin
         diff       = cnt - `EDGE_LAST_MSBF;
         repeat_idx = diff[3:0];
      end
   endfunction

   // every pin crosses two flops before any logic reads it

   pin_sync #(.RST_VAL(`SYNC_RST_CS)) u_cs_sync (
      .CLOCK (CLOCK),
      .RSTN  (RSTN),
      .PIN   (CS_N),
      .LEVEL (cs_n_s)
   );
   pin_sync #(.RST_VAL(`SYNC_RST_LOW)) u_sclk_sync (
      .CLOCK (CLOCK),
      .RSTN  (RSTN),
      .PIN   (SHIFT_CLOCK),
      .LEVEL (sclk_s)
   );
   pin_sync #(.RST_VAL(`SYNC_RST_LOW)) u_comp_sync (
      .CLOCK (CLOCK),
      .RSTN  (RSTN),
      .PIN   (COMP_GE),
      .LEVEL (comp_s)
   );

   // a start needs a seen high level first, so holding low never restarts
   assign start     = cs_n_d_reg & ~cs_n_s;
   assign abort     = cs_n_s;
   assign sclk_fall = sclk_d_reg & ~sclk_s;
   assign sclk_rise = ~sclk_d_reg & sclk_s;
   assign edge_next = edge_cnt_reg + 5'h01;
   assign code      = to_twos(DAC_CODE);
   assign sync_valid  = (flush_cnt_reg == `SYNC_FLUSH);
   assign null_edge   = (edge_next == `EDGE_NULL);
   assign in_msbf     = (edge_next <= `EDGE_LAST_MSBF);
   assign in_lsbf     = (edge_next <= `EDGE_LAST_LSBF);
   // only the fall that carries the last msb-first bit loads the result
   assign result_load = (state_reg == `ST_CONVERT) & sclk_fall & ~start &
                        ~abort & (edge_next == `EDGE_LAST_MSBF);

   // counts the edges the synchronisers need before they show the pins
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         flush_cnt_reg <= `FLUSH_RST;
         cs_n_d_reg    <= `SYNC_RST_LOW;
         sclk_d_reg    <= `SYNC_RST_LOW;
         DIGITAL_PD    <= 1'b1;
      end else begin
         if (!sync_valid) begin
            flush_cnt_reg <= flush_cnt_reg + 2'h1;
         end
         // a select held low through reset must not pass for a fall
         cs_n_d_reg <= sync_valid & cs_n_s;
         sclk_d_reg <= sclk_s;
         DIGITAL_PD <= cs_n_s;
      end
   end

   // the result only moves when a whole conversion has been decided
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RESULT <= {RES_W{1'b0}};
      end else if (result_load) begin
         RESULT <= code;
      end
   end

   // sequencer: start beats abort, abort beats any shift edge
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg     <= `ST_IDLE;
         edge_cnt_reg  <= {`EDGE_CNT_W{1'b0}};
         bit_idx_reg   <= 4'h0;
         DOUT          <= 1'b0;
         DOUT_OE       <= 1'b0;
         INPUT_CONNECT <= 1'b0;
         DAC_CODE      <= {RES_W{1'b0}};
         ANALOG_PD     <= 1'b1;
         DIGITAL_PD    <= 1'b1;
      end else begin
         if (start) begin
            state_reg     <= `ST_SAMPLE;
            edge_cnt_reg  <= {`EDGE_CNT_W{1'b0}};
            INPUT_CONNECT <= 1'b1;
            ANALOG_PD     <= 1'b0;
            DOUT_OE       <= 1'b0;
         end else if (abort) begin
            // deselect ends everything at once, whatever was sent stays sent
            state_reg     <= `ST_IDLE;
            DOUT_OE       <= 1'b0;
            INPUT_CONNECT <= 1'b0;
            ANALOG_PD     <= 1'b1;
         end else begin
            case (state_reg)
               `ST_IDLE: begin
                  // nothing runs until a fresh select fall
                  state_reg <= `ST_IDLE;
               end
               `ST_SAMPLE: begin
                  if (sclk_fall) begin
                     edge_cnt_reg <= edge_next;
                     if (null_edge) begin
                        state_reg     <= `ST_CONVERT;
                        INPUT_CONNECT <= 1'b0;
                        DOUT_OE       <= 1'b1;
                        DOUT          <= 1'b0;
                        DAC_CODE      <= `TRIAL_START;
                        bit_idx_reg   <= 4'hB;
                     end
                  end
               end
               `ST_CONVERT: begin
                  // decide on the rise so the bit is ready by the next fall
                  if (sclk_rise && !ANALOG_PD) begin
                     DAC_CODE[bit_idx_reg] <= comp_s;
                     if (bit_idx_reg == 4'h0) begin
                        ANALOG_PD <= 1'b1;
                     end
                  end
                  if (sclk_fall) begin
                     edge_cnt_reg <= edge_next;
                     if (in_msbf) begin
                        DOUT <= code[bit_idx_reg];
                        if (bit_idx_reg != 4'h0) begin
                           bit_idx_reg               <= bit_idx_reg - 4'h1;
                           DAC_CODE[bit_idx_reg-4'h1] <= 1'b1;
                        end
                     end else if (in_lsbf) begin
                        DOUT <= code[repeat_idx(edge_next)];
                     end else begin
                        // msb repeated, pin released for good
                        DOUT_OE   <= 1'b0;
                        DOUT      <= 1'b0;
                        state_reg <= `ST_DONE;
                     end
                  end
               end
               `ST_DONE: begin
                  // further shift clocks do nothing until deselected
                  state_reg <= `ST_DONE;
               end
               default: begin
                  state_reg <= `ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // sar_adc_serial_readout

// [src/sar_readout_defs.vh]
// constants for the serial readout sequencer of the differential sar converter
// assumes includers are plain verilog-2005 modules
`ifndef SAR_READOUT_DEFS_VH
`define SAR_READOUT_DEFS_VH

// result width and code layout
`define RES_WIDTH        12
`define RES_MSB          11
`define CODE_POS_FULL    12'h7FF
`define CODE_ZERO        12'h000
`define CODE_NEG_FULL    12'h800
`define TRIAL_START      12'h800

// falling shift clock edges counted from the start of a sequence
`define EDGE_CNT_W       5
`define EDGE_NULL        5'h02
`define EDGE_FIRST_DATA  5'h03
`define EDGE_LAST_MSBF   5'h0E
`define EDGE_LAST_LSBF   5'h19
`define EDGE_TRISTATE    5'h1A

// sequencer states
`define ST_IDLE          2'h0
`define ST_SAMPLE        2'h1
`define ST_CONVERT       2'h2
`define ST_DONE          2'h3

// synchroniser reset levels and flush count
`define SYNC_RST_CS      1'h1
`define SYNC_RST_LOW     1'h0
`define FLUSH_RST        2'h0
`define SYNC_FLUSH       2'h2

`endif
